// file: dv/aps_ctrl_model.sv
/* System controller model: mode pins, fault pin pull-up with external
   pull-down, and a carrier for a slave device. Assumes bench commands. */
`timescale 1ns/1ps
module aps_ctrl_model (
  // Commands and clock
  input  wire logic clk_i,
  input  wire logic wake_cmd_i,
  input  wire logic unmute_cmd_i,
  input  wire logic pull_cmd_i,
  // Device side of the pins
  input  wire logic fault_oen_i,
  input  wire logic sync_o_i,
  input  wire logic sync_oen_i,
  output logic      wake_o,
  output logic      unmute_o,
  output logic      fault_pin_o,
  output logic      sync_pin_o
);
  logic [6:0] div_q = 7'h00;
  logic       car_q = 1'b0;
  assign wake_o      = wake_cmd_i;
  assign unmute_o    = unmute_cmd_i;
  // Pull-up unless either party pulls low
  assign fault_pin_o = !pull_cmd_i && fault_oen_i;
  // Only one source on the sync pin at a time
  assign sync_pin_o  = sync_oen_i ? car_q : sync_o_i;
  always @(posedge clk_i) begin
    div_q <= (div_q == 7'h7C) ? 7'h00 : div_q + 7'h01;
    if (div_q == 7'h7C) car_q <= !car_q;
  end
endmodule : aps_ctrl_model

// file: dv/testbench.sv
/* Self-checking bench of the protection supervisor with a controller
   model on the pins. Assumes the design package and a 125 MHz clock. */
`timescale 1ns/1ps
module testbench
  import aps_pkg::*;
;
  logic clk, rst_n, wake_c, unmute_c, pull_c, tfold, otemp, ocur, sload;
  logic ssup, wshort, uv, ov, unbal, unbal_rel, rate_short, wr, rd, ps;
  logic wake, unmute, fpin, spin, syo, syoen, stage, inen, clamp, irq;
  logic fpoen, fpo;
  logic [3:0]  addr, gain;
  logic [4:0]  mode;
  logic [31:0] wdata, rdata, r;
  int          mismatches, checks, cycles, k, n;
  integer      seed;

  aps_top #(.RESTART_TICKS_P(16'h0008)) aps_top_i (
    .CLK_I(clk), .RESETN_I(rst_n), .WAKE_I(wake), .UNMUTE_I(unmute),
    .TFOLD_I(tfold), .OTEMP_I(otemp), .OCUR_I(ocur),
    .SHORT_LOAD_I(sload), .SHORT_SUP_I(ssup), .WIN_SHORT_I(wshort),
    .UV_I(uv), .OV_I(ov), .UNBAL_I(unbal), .UNBAL_REL_I(unbal_rel),
    .FAULT_PIN_I(fpin), .FAULT_PIN_O(fpo), .FAULT_PIN_OEN_O(fpoen),
    .RATE_SHORT_I(rate_short), .SYNC_I(spin), .SYNC_O(syo),
    .SYNC_OEN_O(syoen), .STAGE_EN_O(stage), .INPUT_EN_O(inen),
    .CUR_CLAMP_O(clamp), .GAIN_RED_O(gain), .MODE_O(mode),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .IRQ_O(irq));
  aps_ctrl_model aps_ctrl_model_i (
    .clk_i(clk), .wake_cmd_i(wake_c), .unmute_cmd_i(unmute_c),
    .pull_cmd_i(pull_c), .fault_oen_i(fpoen), .sync_o_i(syo),
    .sync_oen_i(syoen), .wake_o(wake), .unmute_o(unmute),
    .fault_pin_o(fpin), .sync_pin_o(spin));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Divider writes are clamped to the settable carrier range
  function automatic logic [31:0] clamp_div(input logic [31:0] v);
    if (v[8:0] < DIV_MIN) return {23'h0, DIV_MIN};
    else if (v[8:0] > DIV_MAX) return {23'h0, DIV_MAX};
    else return {23'h0, v[8:0]};
  endfunction : clamp_div
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk
  task automatic wait_mode(input logic [4:0] m, input int c);
    for (int i = 0; i < c && mode !== m; i++) tick(1);
    #1;
  endtask : wait_mode
  task automatic setf(input int f, input logic v);
    @(posedge clk);
    case (f)
      0: otemp <= v;
      1: sload <= v;
      2: uv <= v;
      3: ov <= v;
      default: begin
        unbal     <= v;
        unbal_rel <= !v;
      end
    endcase
  endtask : setf
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Longest path is the foldback step plus the restart loops
  always @(posedge clk) begin
    cycles++;
    if (cycles == 98000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    {wake_c, unmute_c, pull_c, tfold, otemp, ocur, sload, ssup} = 8'h00;
    {wshort, uv, ov, unbal, rate_short, wr, rd, rst_n} = 8'h00;
    {unbal_rel, addr, wdata, ps} = 38'h20_0000_0000;
    {mismatches, checks, cycles} = '0;
    seed = 32'h46e5a479;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    tick(4);
    chk({mode, syoen}, {MD_SLEEP, 1'b0});
    rd_chk(ADDR_DIV, {23'h0, DIV_NOM});
    rd_chk(ADDR_MASK, 32'h0);
    rd_chk(4'h2, 32'h0);
    wr_reg(ADDR_DIV, 32'h1FF);
    rd_chk(ADDR_DIV, clamp_div(32'h1FF));
    r = $random(seed);
    wr_reg(ADDR_DIV, r);
    rd_chk(ADDR_DIV, clamp_div(r));
    wr_reg(ADDR_DIV, 32'h64);
    rd_chk(ADDR_DIV, clamp_div(32'h64));
    r = $random(seed);
    wr_reg(ADDR_MASK, r);
    rd_chk(ADDR_MASK, r & 32'hFF);
    n = 0;
    repeat (2000) begin
      tick(1);
      if (spin && !ps) n++;
      ps = spin;
    end
    chk(n >= 7 && n <= 9, 1'b1);
    @(posedge clk);
    wake_c <= 1'b1;
    wait_mode(MD_MUTE, 50);
    chk({mode, stage, inen}, {MD_MUTE, 2'b10});
    @(posedge clk);
    unmute_c <= 1'b1;
    wait_mode(MD_OPER, 50);
    chk({mode, stage, inen}, {MD_OPER, 2'b11});
    @(posedge clk);
    ocur <= 1'b1;
    tick(4);
    chk({mode, stage, clamp, fpoen, fpo}, {MD_OPER, 4'b1100});
    rd_chk(ADDR_IRQ, 32'h2);
    wr_reg(ADDR_MASK, 32'h2);
    tick(2);
    chk(irq, 1'b1);
    @(posedge clk);
    ocur <= 1'b0;
    wr_reg(ADDR_IRQ, 32'h2);
    tick(2);
    chk({irq, clamp, fpoen}, 3'b001);
    for (k = 0; k < 5; k++) begin
      setf(k, 1'b1);
      tick(2);
      if (k == 0) chk(stage, 1'b0);
      tick(2);
      chk({mode, stage, fpoen}, {MD_FAULT, 2'b00});
      tick(2500);
      chk(mode, MD_FAULT);
      setf(k, 1'b0);
      wait_mode(MD_OPER, 6000);
      chk({mode, fpoen}, {MD_OPER, 1'b1});
    end
    setf(0, 1'b1);
    setf(2, 1'b1);
    tick(4);
    setf(0, 1'b0);
    tick(3000);
    chk(mode, MD_FAULT);
    setf(2, 1'b0);
    wait_mode(MD_OPER, 6000);
    chk(mode, MD_OPER);
    @(posedge clk);
    ssup   <= 1'b1;
    wshort <= 1'b1;
    tick(4);
    chk({mode, stage}, {MD_FAULT, 1'b0});
    @(posedge clk);
    ssup <= 1'b0;
    wait_mode(MD_START, 6000);
    tick(2500);
    chk({mode, stage, fpoen}, {MD_START, 2'b00});
    @(posedge clk);
    wshort <= 1'b0;
    tick(1500);
    chk(mode, MD_START);
    wait_mode(MD_OPER, 1500);
    chk(mode, MD_OPER);
    @(posedge clk);
    pull_c <= 1'b1;
    wait_mode(MD_FAULT, 20);
    chk({mode, stage}, {MD_FAULT, 1'b0});
    @(posedge clk);
    pull_c <= 1'b0;
    wait_mode(MD_OPER, 6000);
    chk(mode, MD_OPER);
    @(posedge clk);
    tfold <= 1'b1;
    tick(17000);
    chk({mode, stage, fpoen}, {MD_OPER, 2'b11});
    chk(gain != 4'h0, 1'b1);
    @(posedge clk);
    tfold      <= 1'b0;
    wake_c     <= 1'b0;
    rate_short <= 1'b1;
    rst_n      <= 1'b0;
    tick(12);
    @(posedge clk);
    rst_n <= 1'b1;
    tick(4);
    chk({mode, syoen}, {MD_SLEEP, 1'b1});
    // Slave role: the restart timer now counts edges of the model's carrier
    @(posedge clk);
    wake_c <= 1'b1;
    wait_mode(MD_OPER, 50);
    setf(2, 1'b1);
    tick(4);
    chk(mode, MD_FAULT);
    setf(2, 1'b0);
    wait_mode(MD_OPER, 6000);
    chk({mode, syoen}, {MD_OPER, 1'b1});
    tally_and_finish();
  end
endmodule : testbench

// file: verilog/aps_pkg.sv
/*
  Constants for the amplifier protection supervisor.
  Assumes a 125 MHz system clock and a 320 kHz nominal carrier.
*/
package aps_pkg;
  // Clock and carrier rates
  localparam int CLK_KHZ = 125000;
  localparam int NOM_KHZ = 320;
  localparam int MIN_KHZ = 300;
  localparam int MAX_KHZ = 500;
  // Divider limits: slowest carrier rounds down, fastest rounds up
  localparam logic [8:0] DIV_NOM = 9'(CLK_KHZ / NOM_KHZ);
  localparam logic [8:0] DIV_MAX = 9'(CLK_KHZ / MIN_KHZ);
  localparam logic [8:0] DIV_MIN = 9'((CLK_KHZ + MAX_KHZ - 1) / MAX_KHZ);
  // Restart delay counted in carrier periods
  localparam int RESTART_MS = 100;
  localparam logic [15:0] RESTART_TICKS = 16'(RESTART_MS * NOM_KHZ);
  // Gain foldback step period in carrier periods, and deepest step
  localparam logic [7:0] GAIN_STEP_TICKS = 8'h40;
  localparam logic [3:0] GAIN_MAX = 4'hF;
  // Register byte offsets
  localparam logic [3:0] ADDR_DIV  = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ  = 4'h8;
  localparam logic [3:0] ADDR_MASK = 4'hC;
  // Reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] IRQ_RST  = 8'h00;
  // Event bit positions
  localparam int EV_OTP   = 0;
  localparam int EV_CLAMP = 1;
  localparam int EV_SLOAD = 2;
  localparam int EV_SSUP  = 3;
  localparam int EV_UV    = 4;
  localparam int EV_OV    = 5;
  localparam int EV_UNBAL = 6;
  localparam int EV_EXT   = 7;
  localparam int NEV      = 8;
  // Operating modes
  typedef enum logic [4:0] {
    MD_SLEEP = 5'h01,
    MD_START = 5'h02,
    MD_MUTE  = 5'h04,
    MD_OPER  = 5'h08,
    MD_FAULT = 5'h10
  } aps_mode_t;
endpackage : aps_pkg

// file: verilog/aps_top.sv
/*
  Fault and restart supervisor of a class-D power amplifier, with carrier
  master/slave selection and a small register port.
  Assumes comparator outputs and pins arrive asynchronously; the fault pin
  and carrier sync pin are resolved outside from output enables.
*/
// How it works
// R1 - Overtemperature disables power stage at once
// R2 - Foldback steps gain down, stays operational
// R3 - Overcurrent clamps current, outputs keep switching
// R4 - Load short: off, retry every 100 ms
// R5 - Supply short: window check, 100 ms after clear
// R6 - Start-up halts while outputs read shorted
// R7 - Undervoltage shuts down, restarts after 100 ms
// R8 - Overvoltage disables stages, restarts after 100 ms
// R9 - Unbalance trips, releases within 6 percent
// R10 - Retry class versus removal class restart
// R11 - Any protection but foldback pulls pin low
// R12 - External low on fault pin forces Fault
// R13 - Rate-set strap selects carrier master or slave
// R14 - Carrier settable 300 to 500 kHz, 320 nominal
// R15 - One master per system, others slaves
// R16 - Wake and unmute select the mode
// R17 - Mute: 50 percent switching, inputs disabled
// R18 - Restart delay counted in carrier periods
// R19 - Restart only when every fault allows it
`timescale 1ns/1ps
module aps_top
  import aps_pkg::*;
#(
  parameter logic [15:0] RESTART_TICKS_P = RESTART_TICKS
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RESETN_I,
  // Mode pins
  input  wire logic        WAKE_I,
  input  wire logic        UNMUTE_I,
  // Protection comparators
  input  wire logic        TFOLD_I,
  input  wire logic        OTEMP_I,
  input  wire logic        OCUR_I,
  input  wire logic        SHORT_LOAD_I,
  input  wire logic        SHORT_SUP_I,
  input  wire logic        WIN_SHORT_I,
  input  wire logic        UV_I,
  input  wire logic        OV_I,
  input  wire logic        UNBAL_I,
  input  wire logic        UNBAL_REL_I,
  // Open-drain fault pin
  input  wire logic        FAULT_PIN_I,
  output logic             FAULT_PIN_O,
  output logic             FAULT_PIN_OEN_O,
  // Carrier strap and sync pin
  input  wire logic        RATE_SHORT_I,
  input  wire logic        SYNC_I,
  output logic             SYNC_O,
  output logic             SYNC_OEN_O,
  // Power stage control
  output logic             STAGE_EN_O,
  output logic             INPUT_EN_O,
  output logic             CUR_CLAMP_O,
  output logic [3:0]       GAIN_RED_O,
  output logic [4:0]       MODE_O,
  // Register port
  input  wire logic [3:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic [31:0]      RDATA_O,
  output logic             IRQ_O
);
  ////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic [1:0]  rst_q;
  logic        rst_n;
  logic [14:0] s1_q;
  logic [14:0] s2_q;
  logic        sync3_q;

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) rst_q <= 2'h0;
    else rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // No reset here so the strap is valid when the reset copy releases
  always_ff @(posedge CLK_I) begin
    s1_q    <= {SYNC_I, RATE_SHORT_I, FAULT_PIN_I, UNBAL_REL_I, UNBAL_I,
                OV_I, UV_I, WIN_SHORT_I, SHORT_SUP_I, SHORT_LOAD_I, OCUR_I,
                OTEMP_I, TFOLD_I, UNMUTE_I, WAKE_I};
    s2_q    <= s1_q;
    sync3_q <= s2_q[14];
  end

  wire wake     = s2_q[0];
  wire unmute   = s2_q[1];
  wire tfold    = s2_q[2];
  wire otemp    = s2_q[3];
  wire ocur     = s2_q[4];
  wire sload    = s2_q[5];
  wire ssup     = s2_q[6];
  wire win_shrt = s2_q[7];
  wire uv       = s2_q[8];
  wire ov       = s2_q[9];
  wire unbal    = s2_q[10];
  wire unb_rel  = s2_q[11];
  wire fpin     = s2_q[12];
  wire rate_sh  = s2_q[13];
  wire sync_in  = s2_q[14];

  ////////////////////////////////////////////////////////////////////////
  // Carrier: local divider as master, sync pin edges as slave
  logic       strap_q;
  logic       master_q;
  logic [8:0] div_q;
  logic [8:0] ccnt_q;
  logic       sync_out_q;

  // Greater-or-equal so a smaller divider written mid-period cannot
  // send the counter round the full 9-bit range before the next tick
  wire       ccnt_end = (ccnt_q >= div_q - 9'h001);
  wire       tick = master_q ? ccnt_end : (sync_in & ~sync3_q);     // [R13]
  wire       wr_div = WR_I && (ADDR_I == ADDR_DIV);
  wire [8:0] div_w = WDATA_I[8:0] < DIV_MIN ? DIV_MIN :
                     WDATA_I[8:0] > DIV_MAX ? DIV_MAX : WDATA_I[8:0]; // [R14]

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      strap_q    <= 1'b0;
      master_q   <= 1'b1;
      div_q      <= DIV_NOM;
      ccnt_q     <= 9'h000;
      sync_out_q <= 1'b0;
    end else begin
      strap_q <= 1'b1;
      if (!strap_q) master_q <= ~rate_sh;                            // [R13]
      if (wr_div) div_q <= div_w;                                    // [R14]
      ccnt_q     <= ccnt_end ? 9'h000 : ccnt_q + 9'h001;
      sync_out_q <= ccnt_q < {1'b0, div_q[8:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault conditions
  aps_mode_t   mode_q;
  aps_mode_t   mode_d;
  logic        sl_q;
  logic        ss_q;
  logic        ub_q;
  logic        wchk_q;
  logic        drv_q;
  logic [2:0]  hist_q;
  logic [15:0] rcnt_q;

  wire run   = (mode_q == MD_MUTE) || (mode_q == MD_OPER);
  // Our own pull-down echoes back through the synchroniser for a while
  wire ext   = ~fpin & ~drv_q & ~|hist_q;                            // [R12]
  wire retry = otemp | uv | ov | ub_q | ext;                         // [R10]
  wire trip  = retry | sload | ssup;
  wire clamp = run & ocur;
  wire expd  = tick && (rcnt_q == RESTART_TICKS_P - 16'h0001);       // [R18]
  wire wopen = ~win_shrt;
  wire prot  = otemp | uv | ov | ub_q | sl_q | ss_q | clamp |
               (win_shrt & (mode_q == MD_START));                    // [R11]

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MD_SLEEP: if (wake) mode_d = MD_START;
      MD_START: begin
        if (!wake) mode_d = MD_SLEEP;
        else if (retry) mode_d = MD_FAULT;
        else if (wopen && (!wchk_q || expd))                         // [R6]
          mode_d = unmute ? MD_OPER : MD_MUTE;
      end
      MD_MUTE, MD_OPER: begin
        if (!wake) mode_d = MD_SLEEP;                                // [R16]
        else if (trip) mode_d = MD_FAULT;                  // [R4] [R7] [R8]
        else mode_d = unmute ? MD_OPER : MD_MUTE;                    // [R16]
      end
      MD_FAULT: begin
        if (!wake) mode_d = MD_SLEEP;
        else if (expd && !retry) mode_d = MD_START;                  // [R19]
      end
      default: mode_d = MD_SLEEP;
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MD_SLEEP;
      sl_q   <= 1'b0;
      ss_q   <= 1'b0;
      ub_q   <= 1'b0;
      wchk_q <= 1'b0;
      drv_q  <= 1'b0;
      hist_q <= 3'h0;
      rcnt_q <= 16'h0000;
    end else begin
      mode_q <= mode_d;
      // Latched shorts end at the restart point; a new hit wins
      if (run && sload) sl_q <= 1'b1;                                // [R4]
      else if (expd || mode_q == MD_SLEEP) sl_q <= 1'b0;
      if (run && ssup) ss_q <= 1'b1;                                 // [R5]
      else if (expd || mode_q == MD_SLEEP) ss_q <= 1'b0;
      if (unbal) ub_q <= 1'b1;                                       // [R9]
      else if (unb_rel) ub_q <= 1'b0;
      if (mode_q == MD_FAULT && expd && ss_q) wchk_q <= 1'b1;        // [R5]
      else if (mode_q != MD_START) wchk_q <= 1'b0;
      drv_q  <= prot;                                                // [R11]
      hist_q <= {hist_q[1:0], drv_q};
      // Retry timer free-runs in Fault; in start-up it waits for open
      if (!(mode_q == MD_FAULT || mode_q == MD_START) ||
          (mode_q == MD_START && win_shrt))
        rcnt_q <= 16'h0000;                                          // [R5]
      else if (tick) rcnt_q <= expd ? 16'h0000 : rcnt_q + 16'h0001;  // [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Thermal gain foldback
  logic [3:0] gain_q;
  logic [7:0] gcnt_q;
  wire        gstep = tick && (gcnt_q == GAIN_STEP_TICKS - 8'h01);

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      gain_q <= 4'h0;
      gcnt_q <= 8'h00;
    end else begin
      if (tick) gcnt_q <= gstep ? 8'h00 : gcnt_q + 8'h01;
      if (gstep && tfold && gain_q != GAIN_MAX) gain_q <= gain_q + 4'h1;
      else if (gstep && !tfold && gain_q != 4'h0)                    // [R2]
        gain_q <= gain_q - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers and interrupt
  logic [NEV-1:0] ev_prev_q;
  logic [NEV-1:0] irq_q;
  logic [NEV-1:0] mask_q;
  logic [31:0]    rdata_q;

  wire [NEV-1:0] ev = {ext, ub_q, ov, uv, ss_q, sl_q, clamp, otemp};
  wire [NEV-1:0] rise = ev & ~ev_prev_q;
  wire wr_irq  = WR_I && (ADDR_I == ADDR_IRQ);
  wire wr_mask = WR_I && (ADDR_I == ADDR_MASK);
  wire [NEV-1:0] w1c = wr_irq ? WDATA_I[NEV-1:0] : {NEV{1'b0}};
  wire [31:0] stat = {19'h00000, ext, drv_q, STAGE_EN_O, gain_q,
                      master_q, mode_q};
  wire [31:0] rd_val;
  assign rd_val = (ADDR_I == ADDR_DIV)  ? {23'h000000, div_q} :
                  (ADDR_I == ADDR_STAT) ? stat :
                  (ADDR_I == ADDR_IRQ)  ? {24'h000000, irq_q} :
                  (ADDR_I == ADDR_MASK) ? {24'h000000, mask_q} :
                  32'h00000000;

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ev_prev_q <= {NEV{1'b0}};
      irq_q     <= IRQ_RST;
      mask_q    <= MASK_RST;
      rdata_q   <= 32'h00000000;
    end else begin
      ev_prev_q <= ev;
      irq_q     <= (irq_q & ~w1c) | rise;   // Set wins over clear
      if (wr_mask) mask_q <= WDATA_I[NEV-1:0];
      rdata_q   <= RD_I ? rd_val : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign STAGE_EN_O      = run & ~otemp;                             // [R1]
  assign INPUT_EN_O      = (mode_q == MD_OPER) & ~otemp;             // [R17]
  assign CUR_CLAMP_O     = clamp & ~otemp;                           // [R3]
  assign GAIN_RED_O      = gain_q;
  assign MODE_O          = mode_q;
  assign FAULT_PIN_O     = 1'b0;
  assign FAULT_PIN_OEN_O = ~drv_q;                                   // [R11]
  assign SYNC_O          = sync_out_q;
  assign SYNC_OEN_O      = ~master_q;                                // [R13]
  assign RDATA_O         = rdata_q;
  assign IRQ_O           = |(irq_q & mask_q);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  otp_off_a: assert property (otemp |-> !STAGE_EN_O)              // [R1]
    else $error("stage enabled during overtemperature");
  fold_dir_a: assert property (tfold && $past(tfold) |->          // [R2]
    gain_q >= $past(gain_q)) else $error("gain rose during foldback");
  clamp_run_a: assert property (CUR_CLAMP_O |-> STAGE_EN_O)       // [R3]
    else $error("clamp without switching stage");
  short_off_a: assert property (run && sload && wake |=>          // [R4]
    mode_q == MD_FAULT) else $error("load short did not stop stage");
  win_hold_a: assert property (mode_q == MD_START && win_shrt |=> // [R6]
    !STAGE_EN_O) else $error("start-up passed shorted window");
  uv_off_a: assert property (run && uv && wake |=> ##1            // [R7]
    !STAGE_EN_O) else $error("undervoltage left stage on");
  unb_hold_a: assert property (ub_q && !unb_rel |=> ub_q)         // [R9]
    else $error("unbalance released early");
  restart_time_a: assert property (mode_q == MD_FAULT &&          // [R10]
    mode_d == MD_START |-> expd && !retry)
    else $error("restart outside the retry point");
  pin_drive_a: assert property (prot |=> !FAULT_PIN_OEN_O)        // [R11]
    else $error("fault pin not pulled low");
  ext_fault_a: assert property (run && ext && wake |=>            // [R12]
    mode_q == MD_FAULT) else $error("external fault ignored");
  role_pin_a: assert property (master_q |-> !SYNC_OEN_O)          // [R13]
    else $error("master not driving sync pin");
  div_range_a: assert property (div_q >= DIV_MIN &&               // [R14]
    div_q <= DIV_MAX) else $error("carrier divider out of range");
  sleep_a: assert property (!wake |=> mode_q == MD_SLEEP)         // [R16]
    else $error("wake low did not sleep");
  mute_a: assert property (mode_q == MD_MUTE |-> !INPUT_EN_O)     // [R17]
    else $error("inputs enabled in mute");

  oper_c: cover property (mode_q == MD_START ##1 mode_q == MD_OPER);
  retry_c: cover property (mode_q == MD_FAULT ##1 mode_q == MD_START);
  clamp_c: cover property (CUR_CLAMP_O [*3]);
  irq_c: cover property (IRQ_O);
endmodule : aps_top
